/* bench/flow_peer_model.sv */
// remote serial peer driving the active-low flow-control line
// assumes the bench asks for ready or not ready and a lag in cycles
`timescale 1ns/1ns
module flow_peer_model (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic peerReady,
  input wire logic [3:0] lag,
  // flow-control line, low while the peer accepts data
  output logic clearToSend_n
);
  logic [3:0] lagQ; // cycles left before the line follows
  initial clearToSend_n = 1'h1; // idles deasserted, as a pull-up leaves it
  initial lagQ = 4'h0;
  // line follows the request after the chosen lag
  always @(posedge clk) begin
    if (clearToSend_n === peerReady) begin
      if (lagQ == 4'h0) clearToSend_n <= !peerReady;
      else lagQ <= lagQ - 4'h1;
    end else lagQ <= lag;
  end
endmodule

/* bench/uart_irq_mask_shortcuts_monitor.sv */
// port checker for the event mask and shortcut block
// assumes it is bound onto the top module, one clock domain
`timescale 1ns/1ns
module uart_irq_mask_shortcuts_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin, tasks and interrupt
  input wire logic clearToSend_n,
  input wire logic receiverStartTask,
  input wire logic receiverStopTask,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // start task exactly four cycles after the line was first seen low
  property p_start;
    receiverStartTask |-> $past(clearToSend_n, 5) && !$past(clearToSend_n, 4);
  endproperty
  a_start: assert property (p_start) else $error("start task without line low");
  // stop task exactly four cycles after the line was first seen high
  property p_stop;
    receiverStopTask |-> !$past(clearToSend_n, 5) && $past(clearToSend_n, 4);
  endproperty
  a_stop: assert property (p_stop) else $error("stop task without line high");
  // each task pulse lasts one cycle
  property p_pulse;
    (receiverStartTask |=> !receiverStartTask) and (receiverStopTask |=> !receiverStopTask);
  endproperty
  a_pulse: assert property (p_pulse) else $error("task pulse too long");
  // write answer stands until taken
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  // read answer stands until taken
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  // write answer only after both halves were held
  property p_wrbusy;
    $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
  endproperty
  a_wrbusy: assert property (p_wrbusy) else $error("write answer before both halves");
  // no new read taken while read data waits
  property p_rdbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rdbusy: assert property (p_rdbusy) else $error("read taken during answer");
  // interrupt only falls after a register write
  property p_irqfall;
    $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_irqfall: assert property (p_irqfall) else $error("interrupt fell unasked");
endmodule
bind uart_irq_mask_shortcuts uart_irq_mask_shortcuts_monitor mon (.clk, .rst_n,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .clearToSend_n,
  .receiverStartTask, .receiverStopTask, .irq);

/* bench/uart_irq_mask_shortcuts_test.sv */
// bench for the serial port event mask and shortcut block
// assumes design files, checker and peer model are compiled first
`timescale 1ns/1ns
module uart_irq_mask_shortcuts_test import uart_irq_pkg::*;;
  localparam logic [31:0] ALL_EN = 32'h0002_0287; // every enable bit
  logic clk = 1'h0, rst_n = 1'h0;
  addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, dp = 4'h0, lag = 4'h0; // dp: rx, tx, err, timeout
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, receiverStartTask, receiverStopTask, clearToSend_n, peerReady = 1'h0;
  int bad_count = 0, tests_run = 0, startCnt = 0, stopCnt = 0;
  int posTab[6] = '{POS_FLOWGO, POS_FLOWSTOP, POS_RXBYTE, POS_TXBYTE, POS_ERROR, POS_RXTIMEOUT};
  addr_t offTab[6] = '{OFF_EVT_FLOWGO, OFF_EVT_FLOWSTOP, OFF_EVT_RXBYTE, OFF_EVT_TXBYTE,
    OFF_EVT_ERROR, OFF_RX_TIMEOUT_EVENT};
  always #2 clk = ~clk;
  uart_irq_mask_shortcuts DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clearToSend_n, .byteReceived(dp[0]),
    .byteSent(dp[1]), .errorDetected(dp[2]), .receiverTimeout(dp[3]),
    .receiverStartTask, .receiverStopTask, .irq);
  flow_peer_model peer (.clk, .peerReady, .lag, .clearToSend_n);
  // count task pulses seen
  always @(posedge clk) begin
    if (receiverStartTask === 1'h1) startCnt++;
    if (receiverStopTask === 1'h1) stopCnt++;
  end
  function automatic logic [31:0] bitOf(input int i);
    return 32'h1 << posTab[i];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bus write, address and data offered together
  task automatic wr(input addr_t a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    // answer left waiting one cycle, then taken
    s_axi_bready <= 1'h1;
    @(posedge clk);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask
  // bus read with expected data and response
  task automatic rd(input addr_t a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    // read data left waiting one cycle, then taken
    s_axi_rready <= 1'h1;
    @(posedge clk);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'h0;
  endtask
  task automatic doReset;
    rst_n <= 1'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
  // enable mask through set and clear, one bit at a time
  task automatic t_mask;
    rd(OFF_EVENT_TASK_SHORTCUTS, 32'h0);
    rd(OFF_INTERRUPT_ENABLE_SET, 32'h0);
    wr(OFF_INTERRUPT_ENABLE_SET, 32'hFFFF_FFFF);
    rd(OFF_INTERRUPT_ENABLE_CLEAR, ALL_EN);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_INTERRUPT_ENABLE_CLEAR, bitOf(i));
      wr(OFF_INTERRUPT_ENABLE_SET, 32'h0);
      rd(OFF_INTERRUPT_ENABLE_SET, ALL_EN & ~bitOf(i));
      wr(OFF_INTERRUPT_ENABLE_SET, bitOf(i));
      wr(OFF_INTERRUPT_ENABLE_CLEAR, 32'h0);
      rd(OFF_INTERRUPT_ENABLE_SET, ALL_EN);
    end
    wr(OFF_INTERRUPT_ENABLE_CLEAR, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'h1;
    wr(OFF_INTERRUPT_ENABLE_SET, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    rd(OFF_INTERRUPT_ENABLE_SET, 32'h0000_0087);
    wr(OFF_INTERRUPT_ENABLE_CLEAR, 32'hFFFF_FFFF);
    $display("test mask done");
  endtask
  // each datapath event raises a flag; irq follows the mask
  task automatic t_irq;
    for (int i = 2; i < 6; i++) begin
      @(posedge clk);
      dp <= 4'h1 << (i - 2);
      @(posedge clk);
      dp <= 4'h0;
      repeat (4) @(posedge clk);
      chk("irq", irq, 32'h0);
      rd(offTab[i], 32'h1);
      rd(OFF_EVENT_STATUS, bitOf(i));
      wr(OFF_INTERRUPT_ENABLE_SET, bitOf(i));
      repeat (3) @(posedge clk);
      chk("irq", irq, 32'h1);
      wr(OFF_INTERRUPT_ENABLE_CLEAR, bitOf(i));
      repeat (3) @(posedge clk);
      chk("irq", irq, 32'h0);
      wr(OFF_EVENT_STATUS, bitOf(i));
      rd(offTab[i], 32'h0);
    end
    $display("test irq done");
  endtask
  // flow line edges with shortcuts off, then on with a slow peer
  task automatic t_short;
    peerReady <= 1'h1;
    repeat (10) @(posedge clk);
    chk("start", startCnt, 0);
    rd(OFF_EVT_FLOWGO, 32'h1);
    peerReady <= 1'h0;
    repeat (10) @(posedge clk);
    chk("stop", stopCnt, 0);
    rd(OFF_EVT_FLOWSTOP, 32'h1);
    // lag is loaded while the line rests, so the next change waits for it
    lag <= 4'h5;
    wr(OFF_EVT_FLOWGO, 32'h0);
    wr(OFF_EVT_FLOWSTOP, 32'h0);
    wr(OFF_EVENT_TASK_SHORTCUTS, 32'h3);
    wr(OFF_INTERRUPT_ENABLE_SET, 32'h3);
    peerReady <= 1'h1;
    repeat (14) @(posedge clk);
    chk("start", startCnt, 1);
    chk("irq", irq, 32'h1);
    wr(OFF_EVENT_STATUS, 32'h1);
    peerReady <= 1'h0;
    repeat (14) @(posedge clk);
    chk("stop", stopCnt, 1);
    chk("irq", irq, 32'h1);
    wr(OFF_INTERRUPT_ENABLE_CLEAR, 32'h3);
    wr(OFF_EVENT_TASK_SHORTCUTS, 32'h0);
    $display("test shortcuts done");
  endtask
  // unmapped place, then a reset in mid-run
  task automatic t_misc;
    wr(12'h010, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(12'h010, 32'h0, RESP_SLVERR);
    wr(OFF_RX_TIMEOUT_EVENT, 32'h1);
    rd(OFF_RX_TIMEOUT_EVENT, 32'h1);
    wr(OFF_INTERRUPT_ENABLE_SET, ALL_EN);
    repeat (2) @(posedge clk);
    chk("irq", irq, 32'h1);
    doReset();
    chk("irq", irq, 32'h0);
    rd(OFF_INTERRUPT_ENABLE_CLEAR, 32'h0);
    rd(OFF_RX_TIMEOUT_EVENT, 32'h0);
    $display("test misc done");
  endtask
  initial begin
    doReset();
    t_mask();
    t_irq();
    t_short();
    t_misc();
    summarize();
  end
  // watchdog well past the expected run length
  initial begin
    #80000;
    bad_count++;
    summarize();
  end
endmodule

/* core/axil_slave.sv */
// axi4-lite slave front end, one write and one read outstanding
// assumes the core answers reads combinationally from rdAddr
`timescale 1ns/1ns
module axil_slave
  import uart_irq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstSync_n,
  // write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core side
  reg_if.bus rb
);
  logic awHeld_q; // write address captured
  logic wHeld_q; // write data captured
  addr_t awAddr_q; // captured write address
  logic [31:0] wData_q; // captured masked write data

  // each channel accepts only while its holding slot is empty
  assign awready = ~awHeld_q;
  assign wready = ~wHeld_q;
  assign arready = ~rvalid;
  // write issues once both halves are in and the response slot is free
  assign rb.wrEn = awHeld_q & wHeld_q & ~bvalid;
  assign rb.wrAddr = awAddr_q;
  assign rb.wrData = wData_q;
  assign rb.rdAddr = araddr;

  // capture address and data in either order
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end else if (rb.wrEn) begin
        awHeld_q <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end else if (rb.wrEn) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // write response, error for unmapped addresses
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (rb.wrEn) begin
      bvalid <= 1'b1;
      bresp <= rb.wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data registered on address acceptance
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rb.rdData;
      rresp <= rb.rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

/* core/flow_pin_sync.sv */
// two-flop synchroniser and edge detector for the flow-control pin
// assumes the pin is asynchronous and active low
`timescale 1ns/1ns
module flow_pin_sync
  import uart_irq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstSync_n,
  // raw pin
  input wire logic pinRaw,
  // edge pulses
  output logic wentLow,
  output logic wentHigh
);
  logic meta_q; // first stage, read only by the second
  logic sync_q; // second stage
  logic prev_q; // delayed copy for edges

  // synchroniser chain and edge pulses
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      meta_q <= CTS_PIN_RST;
      sync_q <= CTS_PIN_RST;
      prev_q <= CTS_PIN_RST;
      wentLow <= 1'b0;
      wentHigh <= 1'b0;
    end else begin
      meta_q <= pinRaw;
      sync_q <= meta_q;
      prev_q <= sync_q;
      wentLow <= prev_q & ~sync_q;
      wentHigh <= ~prev_q & sync_q;
    end
  end
endmodule

/* core/reg_if.sv */
// register access carrier between the bus slave and the event core
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface reg_if import uart_irq_pkg::*; ();
  logic wrEn; // one-cycle write strobe
  addr_t wrAddr; // write byte address
  logic [31:0] wrData; // write data, byte lanes already masked
  logic wrHit; // write address is mapped
  addr_t rdAddr; // read byte address
  logic [31:0] rdData; // read data for rdAddr
  logic rdHit; // read address is mapped
  modport bus(output wrEn, output wrAddr, output wrData, output rdAddr,
    input wrHit, input rdData, input rdHit);
  modport core(input wrEn, input wrAddr, input wrData, input rdAddr,
    output wrHit, output rdData, output rdHit);
endinterface

/* core/uart_irq_mask_shortcuts.sv */
// serial port event flags, interrupt enable mask and event-to-task shortcuts
// assumes datapath event inputs are one-cycle pulses on clk; pin is async
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns

// How it works
// - flow-go event with shortcut set starts receiver
// - flow-stop event with shortcut set stops receiver
// - set register writes ones enable; reads enables
// - clear register writes ones disable; reads enables
// - flow-stop event has its own enable bit
// - byte-received event has its own enable bit
// - byte-sent event has its own enable bit
// - pin going low raises flow-go event
// - pin going high raises flow-stop event
module uart_irq_mask_shortcuts
  import uart_irq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flow-control pin, active low
  input wire logic clearToSend_n,
  // datapath event pulses
  input wire logic byteReceived,
  input wire logic byteSent,
  input wire logic errorDetected,
  input wire logic receiverTimeout,
  // receiver task pulses
  output logic receiverStartTask,
  output logic receiverStopTask,
  // interrupt request, active high level
  output logic irq
);
  // spread six event bits onto the 32-bit enable layout
  function automatic logic [31:0] toLayout(input logic [EVT_N-1:0] v);
    logic [31:0] r;
    r = 32'h0;
    r[POS_FLOWGO] = v[EV_FLOWGO];
    r[POS_FLOWSTOP] = v[EV_FLOWSTOP];
    r[POS_RXBYTE] = v[EV_RXBYTE];
    r[POS_TXBYTE] = v[EV_TXBYTE];
    r[POS_ERROR] = v[EV_ERROR];
    r[POS_RXTIMEOUT] = v[EV_RXTIMEOUT];
    return r;
  endfunction

  // gather six event bits from the 32-bit enable layout
  function automatic logic [EVT_N-1:0] fromLayout(input logic [31:0] w);
    logic [EVT_N-1:0] r;
    r = EVT_RST;
    r[EV_FLOWGO] = w[POS_FLOWGO];
    r[EV_FLOWSTOP] = w[POS_FLOWSTOP];
    r[EV_RXBYTE] = w[POS_RXBYTE];
    r[EV_TXBYTE] = w[POS_TXBYTE];
    r[EV_ERROR] = w[POS_ERROR];
    r[EV_RXTIMEOUT] = w[POS_RXTIMEOUT];
    return r;
  endfunction

  // byte offset of each event register
  function automatic addr_t evtOffset(input int idx);
    addr_t r;
    case (idx)
      EV_FLOWGO: r = OFF_EVT_FLOWGO;
      EV_FLOWSTOP: r = OFF_EVT_FLOWSTOP;
      EV_RXBYTE: r = OFF_EVT_RXBYTE;
      EV_TXBYTE: r = OFF_EVT_TXBYTE;
      EV_ERROR: r = OFF_EVT_ERROR;
      default: r = OFF_RX_TIMEOUT_EVENT;
    endcase
    return r;
  endfunction

  logic rstMeta_q; // reset release, first stage
  logic rstSync_n; // reset release, synchronised copy
  logic flowGo; // pin went low pulse
  logic flowStop; // pin went high pulse
  logic [EVT_N-1:0] hwEvt; // hardware event pulses this cycle
  logic [EVT_N-1:0] evtFlag_q; // sticky event flags
  logic [EVT_N-1:0] evtFlag_d; // next event flags
  logic [EVT_N-1:0] intEn_q; // interrupt enable mask
  logic [EVT_N-1:0] intEn_d; // next enable mask
  logic [1:0] shortcut_q; // shortcut enables
  logic [EVT_N-1:0] wrBits; // write data gathered from the layout

  reg_if rb(); // bus to core carrier

  // reset released through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // bus slave front end
  axil_slave u_bus (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rb(rb)
  );

  // flow-control pin synchroniser and edges
  flow_pin_sync u_pin (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .pinRaw(clearToSend_n),
    .wentLow(flowGo),
    .wentHigh(flowStop)
  );

  // collect hardware event pulses
  always_comb begin
    hwEvt = EVT_RST;
    hwEvt[EV_FLOWGO] = flowGo;
    hwEvt[EV_FLOWSTOP] = flowStop;
    hwEvt[EV_RXBYTE] = byteReceived;
    hwEvt[EV_TXBYTE] = byteSent;
    hwEvt[EV_ERROR] = errorDetected;
    hwEvt[EV_RXTIMEOUT] = receiverTimeout;
  end

  // write data seen through the enable layout
  assign wrBits = fromLayout(rb.wrData);

  // next event flags: a hardware event always wins over a clear
  always_comb begin
    evtFlag_d = evtFlag_q;
    for (int i = 0; i < EVT_N; i++) begin
      // own register writes store bit 0
      if (rb.wrEn && rb.wrAddr == evtOffset(i)) begin
        evtFlag_d[i] = rb.wrData[0];
      end
    end
    // status writes clear flags written as one
    if (rb.wrEn && rb.wrAddr == OFF_EVENT_STATUS) begin
      evtFlag_d = evtFlag_d & ~wrBits;
    end
    evtFlag_d = evtFlag_d | hwEvt;
  end

  // sticky event flags
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      evtFlag_q <= EVT_RST;
    end else begin
      evtFlag_q <= evtFlag_d;
    end
  end

  // next enable mask from set and clear writes
  always_comb begin
    intEn_d = intEn_q;
    // ones set, zeros leave bits alone
    if (rb.wrEn && rb.wrAddr == OFF_INTERRUPT_ENABLE_SET) begin
      intEn_d = intEn_q | wrBits;
    end
    // ones clear, zeros leave bits alone
    if (rb.wrEn && rb.wrAddr == OFF_INTERRUPT_ENABLE_CLEAR) begin
      intEn_d = intEn_q & ~wrBits;
    end
  end

  // interrupt enable mask
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      intEn_q <= INTEN_RST;
    end else begin
      intEn_q <= intEn_d;
    end
  end

  // shortcut register, plain read-write
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      shortcut_q <= SHORTCUT_RST;
    end else if (rb.wrEn && rb.wrAddr == OFF_EVENT_TASK_SHORTCUTS) begin
      shortcut_q[0] <= rb.wrData[POS_FLOW_GO_START];
      shortcut_q[1] <= rb.wrData[POS_FLOW_HALT_STOP];
    end
  end

  // receiver tasks fired straight from flow-control events
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      receiverStartTask <= 1'b0;
      receiverStopTask <= 1'b0;
    end else begin
      receiverStartTask <= flowGo & shortcut_q[0];
      receiverStopTask <= flowStop & shortcut_q[1];
    end
  end

  // interrupt level from enabled sticky flags
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evtFlag_q & intEn_q);
    end
  end

  // write address decode
  always_comb begin
    rb.wrHit = 1'b0;
    for (int i = 0; i < EVT_N; i++) begin
      if (rb.wrAddr == evtOffset(i)) begin
        rb.wrHit = 1'b1;
      end
    end
    case (rb.wrAddr)
      OFF_EVENT_TASK_SHORTCUTS: rb.wrHit = 1'b1;
      OFF_INTERRUPT_ENABLE_SET: rb.wrHit = 1'b1;
      OFF_INTERRUPT_ENABLE_CLEAR: rb.wrHit = 1'b1;
      OFF_EVENT_STATUS: rb.wrHit = 1'b1;
      default: ;
    endcase
  end

  // read multiplexer, unmapped reads zero with error
  always_comb begin
    rb.rdData = 32'h0;
    rb.rdHit = 1'b0;
    for (int i = 0; i < EVT_N; i++) begin
      // event registers show their flag in bit 0
      if (rb.rdAddr == evtOffset(i)) begin
        rb.rdData[0] = evtFlag_q[i];
        rb.rdHit = 1'b1;
      end
    end
    case (rb.rdAddr)
      // shortcut enables
      OFF_EVENT_TASK_SHORTCUTS: begin
        rb.rdData[POS_FLOW_GO_START] = shortcut_q[0];
        rb.rdData[POS_FLOW_HALT_STOP] = shortcut_q[1];
        rb.rdHit = 1'b1;
      end
      // both enable registers show the same mask
      OFF_INTERRUPT_ENABLE_SET: begin
        rb.rdData = toLayout(intEn_q);
        rb.rdHit = 1'b1;
      end
      OFF_INTERRUPT_ENABLE_CLEAR: begin
        rb.rdData = toLayout(intEn_q);
        rb.rdHit = 1'b1;
      end
      // gathered sticky flags
      OFF_EVENT_STATUS: begin
        rb.rdData = toLayout(evtFlag_q);
        rb.rdHit = 1'b1;
      end
      default: ;
    endcase
  end
endmodule

/* core/uart_irq_pkg.sv */
// shared constants for the serial port event, interrupt and shortcut block
// assumes a 12-bit byte address space behind a 32-bit register bus
package uart_irq_pkg;
  localparam int ADDR_W = 12; // byte address width seen by the block
  localparam int EVT_N = 6; // number of port events
  typedef logic [ADDR_W-1:0] addr_t;
  // event indices inside the block
  localparam int EV_FLOWGO = 0;
  localparam int EV_FLOWSTOP = 1;
  localparam int EV_RXBYTE = 2;
  localparam int EV_TXBYTE = 3;
  localparam int EV_ERROR = 4;
  localparam int EV_RXTIMEOUT = 5;
  // register byte offsets
  localparam addr_t OFF_EVT_FLOWGO = 12'h100;
  localparam addr_t OFF_EVT_FLOWSTOP = 12'h104;
  localparam addr_t OFF_EVT_RXBYTE = 12'h108;
  localparam addr_t OFF_EVT_TXBYTE = 12'h11C;
  localparam addr_t OFF_EVT_ERROR = 12'h124;
  localparam addr_t OFF_RX_TIMEOUT_EVENT = 12'h144;
  localparam addr_t OFF_EVENT_TASK_SHORTCUTS = 12'h200;
  localparam addr_t OFF_INTERRUPT_ENABLE_SET = 12'h304;
  localparam addr_t OFF_INTERRUPT_ENABLE_CLEAR = 12'h308;
  localparam addr_t OFF_EVENT_STATUS = 12'h30C;
  // enable and status layout bit positions
  localparam int POS_FLOWGO = 0;
  localparam int POS_FLOWSTOP = 1;
  localparam int POS_RXBYTE = 2;
  localparam int POS_TXBYTE = 7;
  localparam int POS_ERROR = 9;
  localparam int POS_RXTIMEOUT = 17;
  // shortcut bit positions
  localparam int POS_FLOW_GO_START = 0;
  localparam int POS_FLOW_HALT_STOP = 1;
  // values after reset
  localparam logic [EVT_N-1:0] EVT_RST = 6'h00;
  localparam logic [EVT_N-1:0] INTEN_RST = 6'h00;
  localparam logic [1:0] SHORTCUT_RST = 2'h0;
  localparam logic CTS_PIN_RST = 1'h1; // pin assumed deasserted at reset
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
